//--- rtl/ramp_profile_defines.vh
// Register offsets, field widths and reset values of the ramp profile block
`ifndef RAMP_PROFILE_DEFINES_VH
`define RAMP_PROFILE_DEFINES_VH
`define OFS_FIRST_THRESHOLD_VELOCITY 8'h1d
`define OFS_SECOND_ACCELERATION 8'h1e
`define OFS_SECOND_THRESHOLD_OFFSET 8'h1f
`define OFS_PEAK_ACCELERATION 8'h20
`define OFS_TARGET_VELOCITY 8'h21
`define OFS_PEAK_DECELERATION 8'h22
`define W_VEL20 20
`define W_ACC 18
`define W_TARGET_VELOCITY 23
`define W_VEL 24
`define RST_VEL20 20'h00000
`define RST_ACC 18'h00000
`define RST_TARGET_VELOCITY 23'h000000
`define TARGET_VELOCITY_LIMIT 23'h7ffe00
`define SEG_IDLE 3'h0
`define SEG_FIRST 3'h1
`define SEG_SECOND 3'h2
`define SEG_HALF 3'h3
`define SEG_PEAK 3'h4
`define SEG_CRUISE 3'h5
`endif

//--- rtl/ramp_profile_parameters.v
// Ramp profile parameter registers and segment acceleration selector
`timescale 1ns/1ps
`include "ramp_profile_defines.vh"

module ramp_profile_parameters
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register access
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   output reg [31:0] rdata,
   output reg rvalid,
   output reg hit,
   // Lower segment limits from neighbouring registers
   input wire [17:0] start_velocity,
   input wire [17:0] stop_velocity,
   input wire [17:0] first_acceleration,
   input wire [17:0] first_deceleration,
   input wire [17:0] second_deceleration,
   // Ramp generator state
   input wire position_mode,
   input wire moving,
   // High while a positioning move ramps down toward stop
   input wire stopping,
   input wire [23:0] actual_velocity,
   // Values to the ramp generator
   output wire [22:0] target_velocity,
   output reg [17:0] accel,
   output reg decelerating,
   output reg [2:0] segment
);

   reg [19:0] first_threshold_velocity_r;
   reg [17:0] second_acceleration_r;
   reg [19:0] second_threshold_offset_r;
   reg [17:0] peak_acceleration_r;
   reg [22:0] target_velocity_r;
   reg [17:0] peak_deceleration_r;
   reg [23:0] v2_abs;
   reg [23:0] vel;
   reg [22:0] target_velocity_clip;
   reg up;
   reg addr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   // Targets whose low 23 bits exceed the limit are clamped; wdata bits above 22 are dropped
   always @*
   begin
      if (wdata[22:0] > `TARGET_VELOCITY_LIMIT)
         target_velocity_clip = `TARGET_VELOCITY_LIMIT;
      else
         target_velocity_clip = wdata[22:0];
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         first_threshold_velocity_r <= `RST_VEL20;
         second_acceleration_r <= `RST_ACC;
         second_threshold_offset_r <= `RST_VEL20;
         peak_acceleration_r <= `RST_ACC;
         target_velocity_r <= `RST_TARGET_VELOCITY;
         peak_deceleration_r <= `RST_ACC;
      end
      else if (wr_en)
      begin
         case (addr)
            `OFS_FIRST_THRESHOLD_VELOCITY: first_threshold_velocity_r <= wdata[19:0];
            `OFS_SECOND_ACCELERATION: second_acceleration_r <= wdata[17:0];
            `OFS_SECOND_THRESHOLD_OFFSET: second_threshold_offset_r <= wdata[19:0];
            `OFS_PEAK_ACCELERATION: peak_acceleration_r <= wdata[17:0];
            // Accepted even mid-motion; the selector follows next cycle
            `OFS_TARGET_VELOCITY: target_velocity_r <= target_velocity_clip;
            `OFS_PEAK_DECELERATION: peak_deceleration_r <= wdata[17:0];
            default: first_threshold_velocity_r <= first_threshold_velocity_r;
         endcase
      end
   end

   always @*
   begin
      case (addr)
         `OFS_FIRST_THRESHOLD_VELOCITY, `OFS_SECOND_ACCELERATION,
         `OFS_SECOND_THRESHOLD_OFFSET, `OFS_PEAK_ACCELERATION,
         `OFS_TARGET_VELOCITY, `OFS_PEAK_DECELERATION: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Unmapped reads return zero
   always @(posedge clk)
   begin
      if (rst)
      begin
         rdata <= 32'h00000000;
         rvalid <= 1'b0;
         hit <= 1'b0;
      end
      else
      begin
         rvalid <= rd_en;
         hit <= (rd_en | wr_en) & addr_ok;
         case (addr)
            `OFS_FIRST_THRESHOLD_VELOCITY: rdata <= {12'h000, first_threshold_velocity_r};
            `OFS_SECOND_ACCELERATION: rdata <= {14'h0000, second_acceleration_r};
            `OFS_SECOND_THRESHOLD_OFFSET: rdata <= {12'h000, second_threshold_offset_r};
            `OFS_PEAK_ACCELERATION: rdata <= {14'h0000, peak_acceleration_r};
            `OFS_TARGET_VELOCITY: rdata <= {9'h000, target_velocity_r};
            `OFS_PEAK_DECELERATION: rdata <= {14'h0000, peak_deceleration_r};
            default: rdata <= 32'h00000000;
         endcase
      end
   end

   assign target_velocity = target_velocity_r;

   ////////////////////////////////////////////////////////////////////////////
   // Segment selection

   // Offset below target; saturates at zero when target is small
   always @*
   begin
      vel = actual_velocity[23] ? (~actual_velocity + 24'h000001) : actual_velocity;
      if ({1'b0, target_velocity_r} > {4'h0, second_threshold_offset_r})
         v2_abs = {1'b0, target_velocity_r} - {4'h0, second_threshold_offset_r};
      else
         v2_abs = 24'h000000;
      up = vel < {1'b0, target_velocity_r};
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         accel <= `RST_ACC;
         decelerating <= 1'b0;
         segment <= `SEG_IDLE;
      end
      else if (!moving)
      begin
         accel <= `RST_ACC;
         decelerating <= 1'b0;
         segment <= `SEG_IDLE;
      end
      else if (!position_mode)
      begin
         accel <= peak_acceleration_r;
         decelerating <= ~up & (vel != {1'b0, target_velocity_r});
         segment <= (vel == {1'b0, target_velocity_r}) ? `SEG_CRUISE : `SEG_PEAK;
      end
      else if (!stopping && vel == {1'b0, target_velocity_r})
      begin
         accel <= `RST_ACC;
         decelerating <= 1'b0;
         segment <= `SEG_CRUISE;
      end
      else if (up && !stopping)
      begin
         // Rising through the segments in order
         decelerating <= 1'b0;
         if (first_threshold_velocity_r != `RST_VEL20 &&
             vel < {4'h0, first_threshold_velocity_r})
         begin
            accel <= first_acceleration;
            segment <= `SEG_FIRST;
         end
         else if (first_threshold_velocity_r != `RST_VEL20 && vel < v2_abs)
         begin
            accel <= second_acceleration_r;
            segment <= `SEG_SECOND;
         end
         else if (second_threshold_offset_r != `RST_VEL20 && vel >= v2_abs)
         begin
            accel <= {1'b0, peak_acceleration_r[17:1]};
            segment <= `SEG_HALF;
         end
         else
         begin
            // No first segments when threshold is zero
            accel <= peak_acceleration_r;
            segment <= `SEG_PEAK;
         end
      end
      else
      begin
         // Falling back down in reverse order
         decelerating <= 1'b1;
         if (second_threshold_offset_r != `RST_VEL20 && vel >= v2_abs)
         begin
            accel <= {1'b0, peak_deceleration_r[17:1]};
            segment <= `SEG_HALF;
         end
         else if (vel >= v2_abs ||
                  first_threshold_velocity_r == `RST_VEL20)
         begin
            accel <= peak_deceleration_r;
            segment <= `SEG_PEAK;
         end
         else if (vel > {4'h0, first_threshold_velocity_r})
         begin
            accel <= second_deceleration;
            segment <= `SEG_SECOND;
         end
         else
         begin
            accel <= (vel > {6'h00, stop_velocity}) ? first_deceleration : `RST_ACC;
            segment <= `SEG_FIRST;
         end
      end
   end

endmodule // ramp_profile_parameters

//--- sim/ramp_profile_parameters_properties.sv
// Port assertions for the ramp profile parameter block
`timescale 1ns/1ps
module ramp_profile_parameters_properties
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register access
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire [31:0] rdata,
   input wire rvalid,
   input wire hit,
   // Ramp side
   input wire moving,
   input wire [22:0] target_velocity,
   input wire [17:0] accel
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence tgt_wr;
      wr_en && addr == 8'h21;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   map_hit_a: assert property ((wr_en || rd_en) && addr >= 8'h1d && addr <= 8'h22 |=> hit)
      else $error("mapped access gave no hit");
   unmapped_miss_a: assert property ((wr_en || rd_en) && addr > 8'h22 |=> !hit)
      else $error("unmapped access gave a hit");
   read_valid_a: assert property (rd_en |=> rvalid)
      else $error("read not answered");
   valid_cause_a: assert property (rvalid |-> $past(rd_en))
      else $error("answer without read");
   target_load_a: assert property ((tgt_wr and (wdata <= 32'h7ffe00)) |=>
      target_velocity == $past(wdata[22:0])) else $error("target not loaded");
   target_clamp_a: assert property ((tgt_wr and (wdata[31:23] == 9'h0
      && wdata[22:0] > 23'h7ffe00)) |=> target_velocity == 23'h7ffe00) else $error("no clamp");
   moving_take_a: assert property (moving ##0 tgt_wr ##0 wdata < 32'h1000 |=>
      target_velocity == $past(wdata[22:0])) else $error("target ignored in motion");
   target_read_a: assert property (rd_en && addr == 8'h21 |=>
      rdata == {9'h0, $past(target_velocity)}) else $error("target readback wrong");
   reset_clear_a: assert property ($fell(rst) |-> target_velocity == 23'h0 && accel == 18'h0)
      else $error("reset left values");
endmodule // ramp_profile_parameters_properties

//--- sim/ramp_profile_parameters_tb.sv
// Self-checking bench for the ramp profile parameter block
`timescale 1ns/1ps
module ramp_profile_parameters_tb;
   reg clk = 0, rst = 1, wr_en = 0, rd_en = 0, position_mode = 1, moving = 0, stopping = 0;
   // Every positioning target written stays above the start velocity
   reg [17:0] start_velocity = 18'h4, stop_velocity = 18'ha;
   reg [7:0] addr = 0;
   reg [31:0] wdata = 0;
   reg [23:0] actual_velocity = 0;
   wire [31:0] rdata;
   wire rvalid, hit, decelerating;
   wire [22:0] target_velocity;
   wire [17:0] accel;
   wire [2:0] segment;
   integer error_cnt = 0, n_checks = 0, i;
   // Rows: offset, write data, read-back
   reg [95:0] rows [0:7] = '{{32'h1d, 32'hffffffff, 32'h000fffff},
      {32'h1e, 32'hffffffff, 32'h0003ffff}, {32'h1f, 32'hffffffff, 32'h000fffff},
      {32'h20, 32'hffffffff, 32'h0003ffff}, {32'h21, 32'hffffffff, 32'h007ffe00},
      {32'h21, 32'h007ffe01, 32'h007ffe00}, {32'h22, 32'hffffffff, 32'h0003ffff},
      {32'h23, 32'hffffffff, 32'h00000000}};
   ramp_profile_parameters ramp_profile_parameters_inst (.clk, .rst, .wr_en, .rd_en, .addr,
      .wdata, .rdata, .rvalid, .hit, .start_velocity, .stop_velocity, .stopping,
      .first_acceleration(18'h11), .first_deceleration(18'h5), .second_deceleration(18'h6),
      .position_mode, .moving, .actual_velocity, .target_velocity, .accel, .decelerating,
      .segment);
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] g, input [31:0] e);
   begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
   begin
      @(negedge clk) {wr_en, addr, wdata} = {1'b1, a, d};
      @(negedge clk) wr_en = 0;
      chk(hit, a >= 8'h1d && a <= 8'h22);
   end
   endtask
   task rd(input [7:0] a, input [31:0] e);
   begin
      @(negedge clk) {rd_en, addr} = {1'b1, a};
      @(negedge clk) rd_en = 0;
      chk(rvalid, 1);
      chk(rdata, e);
   end
   endtask
   // Accel is registered, so one rising edge must pass after the velocity moves; the task waits two
   task sg(input [23:0] v, input [17:0] e);
   begin
      @(negedge clk) actual_velocity = v;
      repeat (2) @(negedge clk);
      chk(accel, e);
   end
   endtask
   task stop_test;
   begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #100000 error_cnt = error_cnt + 1;
      stop_test;
   end
   initial
   begin
      repeat (6) @(negedge clk);
      rst = 0;
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(rows[i][71:64], rows[i][63:32]);
         rd(rows[i][71:64], rows[i][31:0]);
      end
      @(negedge clk) rst = 1;
      repeat (6) @(negedge clk);
      rst = 0;
      for (i = 8'h1d; i <= 8'h22; i = i + 1)
         rd(i, 0);
      wr(8'h1d, 100);
      wr(8'h1e, 8'h22);
      wr(8'h1f, 50);
      wr(8'h20, 8'h40);
      wr(8'h21, 1000);
      moving = 1;
      sg(10, 18'h11);
      chk(segment, 1);
      sg(500, 18'h22);
      sg(980, 18'h20);
      chk(segment, 3);
      wr(8'h1f, 0);
      // No half segment left, second acceleration runs up to the target
      sg(981, 18'h22);
      chk(segment, 2);
      wr(8'h1d, 0);
      sg(10, 18'h40);
      chk(segment, 4);
      sg(999, 18'h40);
      chk(segment, 4);
      position_mode = 0;
      sg(1100, 18'h40);
      chk(decelerating, 1);
      chk(segment, 4);
      sg(10, 18'h40);
      wr(8'h21, 5);
      repeat (2) @(negedge clk);
      chk(target_velocity, 5);
      chk(decelerating, 1);
      // Positioning descent toward the stop velocity
      position_mode = 1;
      stopping = 1;
      wr(8'h21, 1000);
      wr(8'h1d, 100);
      wr(8'h1f, 50);
      wr(8'h22, 8'h30);
      sg(990, 18'h18);
      chk(segment, 3);
      chk(decelerating, 1);
      sg(500, 18'h6);
      chk(segment, 2);
      sg(50, 18'h5);
      chk(segment, 1);
      sg(8, 18'h0);
      wr(8'h1d, 0);
      sg(500, 18'h30);
      chk(segment, 4);
      stop_test;
   end
endmodule // ramp_profile_parameters_tb
bind ramp_profile_parameters ramp_profile_parameters_properties
   ramp_profile_parameters_properties_inst (.clk, .rst, .wr_en, .rd_en, .addr, .wdata,
   .rdata, .rvalid, .hit, .moving, .target_velocity, .accel);
